/* hdl/lgd_byte_ram.sv */
// Byte-wide record store with one write port and a registered read port.
// Assumes the caller never needs read-during-write of the same address.
`timescale 1ns/1ns
module lgd_byte_ram
  import lgd_pkg::*;
#(
  parameter int DEPTH = 496,
  parameter int AW = 9
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Write side
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [7:0] wdata_i,
  // Read side
  input wire logic [AW-1:0] raddr_i,
  output logic [7:0] rdata_o
);

  logic [7:0] mem [DEPTH];

  // ************************************************************
  // Array has no reset; valid marks upstream hide stale bytes
  // ************************************************************
  always_ff @(posedge ref_clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= 8'h00;
    end
    else
    begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule

/* hdl/lgd_defs.svh */
// Byte offsets, fixed values and limits of the two log sectors.
// Assumes one byte-wide sector image of 512 bytes per log read.
`ifndef LGD_DEFS_SVH
`define LGD_DEFS_SVH

// ************************************************************
// Log addresses served or described
// ************************************************************
`define LGD_LOG_DIR 8'h00
`define LGD_LOG_ERR 8'h03
`define LGD_LOG_NCQ 8'h10
`define LGD_LOG_PHY 8'h11
`define LGD_LOG_QM 8'h12
`define LGD_LOG_RA 8'h15
`define LGD_LOG_VEND_LO 8'h80
`define LGD_LOG_VEND_HI 8'h9F

// ************************************************************
// Directory contents
// ************************************************************
`define LGD_DIR_VERSION 16'h0001
`define LGD_DIR_NO_DIR 16'h0000
`define LGD_VEND_SECTORS 8'h10
`define LGD_ERR_SECTORS 8'h01

// ************************************************************
// Error log sector layout
// ************************************************************
`define LGD_ERR_VERSION 8'h01
`define LGD_ERR_INDEX_OFS 9'h002
`define LGD_ERR_INDEX_HI_OFS 9'h003
`define LGD_ERR_REC_OFS 9'h004
`define LGD_ERR_REC_END 9'h1F3
`define LGD_ERR_COUNT_OFS 9'h1F4
`define LGD_ERR_COUNT_HI_OFS 9'h1F5
`define LGD_SUM_OFS 9'h1FF
`define LGD_SECTOR_LAST 9'h1FF
`define LGD_REC1_BASE 9'h07C
`define LGD_REC2_BASE 9'h0F8
`define LGD_REC3_BASE 9'h174
`define LGD_CMD_LAST 6'h11
`define LGD_ESNAP_LAST 6'h21
`define LGD_SNAP_ERR 3'h5
`define LGD_COUNT_MAX 16'hFFFF

`endif

/* hdl/lgd_log_unit.sv */
// Log unit: records device errors and streams the directory and error log sectors.
// Assumes snapshots are held steady from the accepted error event until err_ready_o returns.
//
// Contract
// - Directory version word is 0001h at sector start.
// - Version word 0000h would mean no directory exists.
// - Host vendor logs 80h-9Fh report sixteen sectors each.
// - Sector count per log address sits at twice the address, low byte first.
// - Byte 020h shows queuing support; byte 021h is zero.
// - Byte 022h shows link event counter support; byte 023h is zero.
// - Byte 024h shows queue management support; byte 025h is zero.
// - Byte 02Ah shows rebuild-assist support; 02Bh zero; reserved bytes zero.
// - Error sector: version, index, four records, count, checksum at fixed offsets.
// - Error sector version byte is 01h.
// - Index names newest record, zero when empty, only 0 to 4.
// - Four records rotate; the fifth error overwrites the first.
// - Records never written read back as zero bytes.
// - Errors caused by faulty host commands are neither logged nor counted.
// - Record holds five 18-byte command snapshots then a 34-byte error snapshot.
// - Command snapshot field order ends with command, reserved, millisecond stamp.
// - Command snapshot pairs: newest value low, previous value high.
// - Error snapshot pairs: value with bit 7 clear low, set high.
// - Error snapshot order: error, pairs, head, status, vendor, state, hours.
// - State low nibble codes the power state; high nibble vendor defined.
// - State reflects power state when failing command was issued.
// - Lifetime error count saturates at its maximum.
// - Error log is served at address 03h and is read only.
`timescale 1ns/1ns
`include "lgd_defs.svh"
module lgd_log_unit
  import lgd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Feature support flags
  input wire lgd_support_type support_i,
  // Log read request
  input wire logic req_valid_i,
  input wire logic [7:0] req_log_i,
  output logic req_ready_o,
  output logic req_abort_o,
  // Error event
  input wire logic err_valid_i,
  input wire logic err_host_fault_i,
  input wire lgd_cmd_snap_type [4:0] cmd_snap_i,
  input wire lgd_err_snap_type err_snap_i,
  output logic err_ready_o,
  // Sector byte stream
  output lgd_byte_type byte_o
);

  lgd_state_type st;
  lgd_state_type next_st;
  logic ram_we;
  logic [7:0] ram_wdata;
  logic [8:0] ram_raddr;
  logic [7:0] ram_rdata;
  logic [7:0] cur_byte;
  logic [8:0] rec_addr;
  logic [1:0] rec_sel;

  // ************************************************************
  // Snapshot serialisers
  // ************************************************************
  function automatic logic [7:0] cmd_byte(input lgd_cmd_snap_type s, input logic [4:0] i);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      5'h00: b = s.dev_ctl;
      5'h01: b = s.feat_cur;
      5'h02: b = s.feat_prev;
      5'h03: b = s.cnt_cur;
      5'h04: b = s.cnt_prev;
      5'h05: b = s.sec_cur;
      5'h06: b = s.sec_prev;
      5'h07: b = s.cyl_lo_cur;
      5'h08: b = s.cyl_lo_prev;
      5'h09: b = s.cyl_hi_cur;
      5'h0A: b = s.cyl_hi_prev;
      5'h0B: b = s.dev_head;
      5'h0C: b = s.command;
      5'h0D: b = 8'h00;
      5'h0E: b = s.stamp_ms[7:0];
      5'h0F: b = s.stamp_ms[15:8];
      5'h10: b = s.stamp_ms[23:16];
      5'h11: b = s.stamp_ms[31:24];
      default: b = 8'h00;
    endcase
    return b;
  endfunction

  function automatic logic [7:0] esnap_byte(input lgd_err_snap_type s, input logic [5:0] i);
    logic [7:0] b;
    b = 8'h00;
    unique case (i)
      6'h00: b = 8'h00;
      6'h01: b = s.error;
      6'h02: b = s.cnt_hob0;
      6'h03: b = s.cnt_hob1;
      6'h04: b = s.sec_hob0;
      6'h05: b = s.sec_hob1;
      6'h06: b = s.cyl_lo_hob0;
      6'h07: b = s.cyl_lo_hob1;
      6'h08: b = s.cyl_hi_hob0;
      6'h09: b = s.cyl_hi_hob1;
      6'h0A: b = s.dev_head;
      6'h0B: b = s.status;
      6'h1F: b = {s.state_vendor, s.state};
      6'h20: b = s.life_hours[7:0];
      6'h21: b = s.life_hours[15:8];
      default: b = s.vendor[5'(i - 6'h0C)];
    endcase
    return b;
  endfunction

  // Sector count that the directory reports for one log address
  function automatic logic [7:0] dir_count(input logic [7:0] a, input lgd_support_type f);
    logic [7:0] c;
    c = 8'h00;
    if (a == `LGD_LOG_ERR)
    begin
      c = `LGD_ERR_SECTORS;
    end
    else if (a >= `LGD_LOG_VEND_LO && a <= `LGD_LOG_VEND_HI)
    begin
      c = `LGD_VEND_SECTORS;
    end
    else if (a == `LGD_LOG_NCQ)
    begin
      c = {7'h00, f.ncq};
    end
    else if (a == `LGD_LOG_PHY)
    begin
      c = {7'h00, f.phy_events};
    end
    else if (a == `LGD_LOG_QM)
    begin
      c = {7'h00, f.queue_mgmt};
    end
    else if (a == `LGD_LOG_RA)
    begin
      c = {7'h00, f.rebuild};
    end
    return c;
  endfunction

  // ************************************************************
  // Record store
  // ************************************************************
  lgd_byte_ram #(
    .DEPTH(496),
    .AW(9)
  ) u_ram (
    .ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i),
    .we_i(ram_we),
    .waddr_i(st.waddr),
    .wdata_i(ram_wdata),
    .raddr_i(ram_raddr),
    .rdata_o(ram_rdata)
  );

  // ************************************************************
  // Handshakes
  // ************************************************************
  // Error events win over reads so a stream never sees a half-written record
  assign err_ready_o = (st.phase == LGD_IDLE);
  assign req_ready_o = (st.phase == LGD_IDLE) && !st.run_d && !err_valid_i;
  assign req_abort_o = st.abort;
  assign byte_o = st.out;

  assign ram_we = (st.phase == LGD_RECORD);
  assign ram_wdata = (st.snap == `LGD_SNAP_ERR) ? esnap_byte(err_snap_i, st.sbyte) :
                     cmd_byte(cmd_snap_i[st.snap], st.sbyte[4:0]);
  assign ram_raddr = st.pos - `LGD_ERR_REC_OFS;
  assign rec_addr = st.pos_d - `LGD_ERR_REC_OFS;

  always_comb
  begin
    if (rec_addr < `LGD_REC1_BASE)
    begin
      rec_sel = 2'h0;
    end
    else if (rec_addr < `LGD_REC2_BASE)
    begin
      rec_sel = 2'h1;
    end
    else if (rec_addr < `LGD_REC3_BASE)
    begin
      rec_sel = 2'h2;
    end
    else
    begin
      rec_sel = 2'h3;
    end
  end

  // ************************************************************
  // Byte of the sector at the delayed position
  // ************************************************************
  always_comb
  begin
    cur_byte = 8'h00;
    if (st.sel_err)
    begin
      if (st.pos_d == 9'h000)
      begin
        cur_byte = `LGD_ERR_VERSION;
      end
      else if (st.pos_d == `LGD_ERR_INDEX_OFS)
      begin
        cur_byte = {5'h00, st.index};
      end
      else if (st.pos_d >= `LGD_ERR_REC_OFS && st.pos_d <= `LGD_ERR_REC_END)
      begin
        cur_byte = st.filled[rec_sel] ? ram_rdata : 8'h00;
      end
      else if (st.pos_d == `LGD_ERR_COUNT_OFS)
      begin
        cur_byte = st.count[7:0];
      end
      else if (st.pos_d == `LGD_ERR_COUNT_HI_OFS)
      begin
        cur_byte = st.count[15:8];
      end
      else if (st.pos_d == `LGD_SUM_OFS)
      begin
        cur_byte = 8'h00 - st.sum;
      end
    end
    else
    begin
      if (st.pos_d[8:1] == `LGD_LOG_DIR)
      begin
        // A zero word here would tell the host there is no directory
        cur_byte = st.pos_d[0] ? 8'(`LGD_DIR_VERSION >> 8) : 8'(`LGD_DIR_VERSION);
      end
      else if (!st.pos_d[0])
      begin
        cur_byte = dir_count(st.pos_d[8:1], support_i);
      end
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb
  begin
    next_st = st;
    next_st.abort = 1'b0;
    next_st.run_d = (st.phase == LGD_STREAM);
    next_st.pos_d = st.pos;
    next_st.out.valid = st.run_d;
    next_st.out.last = st.run_d && (st.pos_d == `LGD_SECTOR_LAST);
    next_st.out.data = st.run_d ? cur_byte : 8'h00;
    if (st.run_d)
    begin
      next_st.sum = st.sum + cur_byte;
    end
    unique case (st.phase)
      LGD_IDLE:
      begin
        if (err_valid_i && !err_host_fault_i)
        begin
          next_st.phase = LGD_RECORD;
          next_st.snap = 3'h0;
          next_st.sbyte = 6'h00;
          unique case (st.wp)
            2'h0: next_st.waddr = 9'h000;
            2'h1: next_st.waddr = `LGD_REC1_BASE;
            2'h2: next_st.waddr = `LGD_REC2_BASE;
            2'h3: next_st.waddr = `LGD_REC3_BASE;
          endcase
        end
        else if (req_valid_i && req_ready_o)
        begin
          // Only the directory and the error log are readable; nothing writes them
          if (req_log_i == `LGD_LOG_DIR || req_log_i == `LGD_LOG_ERR)
          begin
            next_st.phase = LGD_STREAM;
            next_st.sel_err = (req_log_i == `LGD_LOG_ERR);
            next_st.pos = 9'h000;
            next_st.sum = 8'h00;
          end
          else
          begin
            next_st.abort = 1'b1;
          end
        end
      end
      LGD_RECORD:
      begin
        next_st.waddr = st.waddr + 9'h001;
        next_st.sbyte = st.sbyte + 6'h01;
        if (st.snap != `LGD_SNAP_ERR && st.sbyte == `LGD_CMD_LAST)
        begin
          next_st.snap = st.snap + 3'h1;
          next_st.sbyte = 6'h00;
        end
        else if (st.snap == `LGD_SNAP_ERR && st.sbyte == `LGD_ESNAP_LAST)
        begin
          next_st.phase = LGD_IDLE;
          next_st.filled[st.wp] = 1'b1;
          next_st.index = {1'b0, st.wp} + 3'h1;
          next_st.wp = st.wp + 2'h1;
          if (st.count != `LGD_COUNT_MAX)
          begin
            next_st.count = st.count + 16'h0001;
          end
        end
      end
      LGD_STREAM:
      begin
        next_st.pos = st.pos + 9'h001;
        if (st.pos == `LGD_SECTOR_LAST)
        begin
          next_st.phase = LGD_IDLE;
        end
      end
      default:
      begin
        next_st.phase = LGD_IDLE;
      end
    endcase
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

endmodule

/* hdl/lgd_pkg.sv */
// Types shared by the log unit: snapshots, phases and the state record.
// Assumes the defines header is included by the modules that use it.
package lgd_pkg;

  // ************************************************************
  // Power state code kept in the error snapshot
  // ************************************************************
  typedef enum logic [3:0] {
    LGD_PWR_UNKNOWN = 4'h0,
    LGD_PWR_SLEEP = 4'h1,
    LGD_PWR_STANDBY = 4'h2,
    LGD_PWR_ACTIVE = 4'h3,
    LGD_PWR_SCAN = 4'h4
  } lgd_pwr_type;

  // ************************************************************
  // Snapshots handed in with an error event
  // ************************************************************
  typedef struct packed {
    logic [7:0] dev_ctl;
    logic [7:0] feat_cur;
    logic [7:0] feat_prev;
    logic [7:0] cnt_cur;
    logic [7:0] cnt_prev;
    logic [7:0] sec_cur;
    logic [7:0] sec_prev;
    logic [7:0] cyl_lo_cur;
    logic [7:0] cyl_lo_prev;
    logic [7:0] cyl_hi_cur;
    logic [7:0] cyl_hi_prev;
    logic [7:0] dev_head;
    logic [7:0] command;
    logic [31:0] stamp_ms;
  } lgd_cmd_snap_type;

  typedef struct packed {
    logic [7:0] error;
    logic [7:0] cnt_hob0;
    logic [7:0] cnt_hob1;
    logic [7:0] sec_hob0;
    logic [7:0] sec_hob1;
    logic [7:0] cyl_lo_hob0;
    logic [7:0] cyl_lo_hob1;
    logic [7:0] cyl_hi_hob0;
    logic [7:0] cyl_hi_hob1;
    logic [7:0] dev_head;
    logic [7:0] status;
    logic [18:0][7:0] vendor;
    logic [3:0] state_vendor;
    lgd_pwr_type state;
    logic [15:0] life_hours;
  } lgd_err_snap_type;

  typedef struct packed {
    logic ncq;
    logic phy_events;
    logic queue_mgmt;
    logic rebuild;
  } lgd_support_type;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } lgd_byte_type;

  // ************************************************************
  // Control state of the log unit
  // ************************************************************
  typedef enum logic [1:0] {
    LGD_IDLE = 2'b00,
    LGD_RECORD = 2'b01,
    LGD_STREAM = 2'b10
  } lgd_phase_type;

  typedef struct packed {
    lgd_phase_type phase;
    logic sel_err;
    logic [8:0] pos;
    logic [8:0] pos_d;
    logic run_d;
    logic [2:0] snap;
    logic [5:0] sbyte;
    logic [8:0] waddr;
    logic [1:0] wp;
    logic [3:0] filled;
    logic [2:0] index;
    logic [15:0] count;
    logic [7:0] sum;
    lgd_byte_type out;
    logic abort;
  } lgd_state_type;

endpackage

/* tb/lgd_chk.sv */
// Checker for the log unit ports: request timing and sector content.
// Assumes one clock domain; the bind sits at the foot of this file.
`timescale 1ns/1ns
module lgd_chk
  import lgd_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Handshakes
  input wire logic req_valid_i,
  input wire logic [7:0] req_log_i,
  input wire logic req_ready_o,
  input wire logic req_abort_o,
  input wire logic err_valid_i,
  input wire logic err_host_fault_i,
  input wire logic err_ready_o,
  // Byte stream
  input wire lgd_byte_type byte_o
);
  logic [8:0] pos;
  logic [7:0] sum;
  logic sel_err;
  wire logic take = req_valid_i && req_ready_o;
  wire logic good = req_log_i == 8'h00 || req_log_i == 8'h03;
  wire logic err_take = err_valid_i && err_ready_o;
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Position follows the stream itself, so a lost byte shifts every later check of that sector
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      pos <= 9'h000;
      sum <= 8'h00;
      sel_err <= 1'b0;
    end
    else
    begin
      pos <= byte_o.valid ? (byte_o.last ? 9'h000 : pos + 9'h001) : pos;
      sum <= byte_o.valid ? (byte_o.last ? 8'h00 : 8'(sum + byte_o.data)) : sum;
      sel_err <= take ? req_log_i == 8'h03 : sel_err;
    end
  a_abort_pulse: assert property (take && !good |=> req_abort_o ##1 !req_abort_o)
    else $error("abort pulse missing");
  a_first_byte: assert property (take && good |-> ##3 byte_o.valid && byte_o.data == 8'h01)
    else $error("first sector byte wrong");
  a_stream_run: assert property (byte_o.valid && !byte_o.last |=> byte_o.valid)
    else $error("gap in sector stream");
  a_last_pos: assert property (byte_o.valid |-> byte_o.last == (pos == 9'h1FF))
    else $error("last flag misplaced");
  a_sum_zero: assert property (byte_o.last && sel_err |-> 8'(sum + byte_o.data) == 8'h00)
    else $error("error log checksum wrong");
  a_index_range: assert property (byte_o.valid && sel_err && pos == 9'h002 |-> byte_o.data <= 8'h04)
    else $error("index out of range");
  a_vendor_count: assert property (byte_o.valid && !sel_err && pos inside {[9'h100:9'h13F]}
    |-> byte_o.data == (pos[0] ? 8'h00 : 8'h10))
    else $error("vendor log size wrong");
  a_dir_zero: assert property (byte_o.valid && !sel_err && pos inside {[9'h021:9'h02F]}
    && (pos[0] || pos inside {[9'h026:9'h029], [9'h02C:9'h02F]}) |-> byte_o.data == 8'h00)
    else $error("directory zero byte set");
  a_err_busy: assert property (err_take && !err_host_fault_i
    |=> (!err_ready_o) [*8] ##116 !err_ready_o ##1 err_ready_o)
    else $error("record write time wrong");
  a_fault_drop: assert property (err_take && err_host_fault_i |=> err_ready_o)
    else $error("host fault was recorded");
  c_dir_read: cover property (take && req_log_i == 8'h00);
  c_err_last: cover property (byte_o.last && sel_err);
  c_fault: cover property (err_take && err_host_fault_i);
endmodule
bind lgd_log_unit lgd_chk u_chk (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .req_valid_i(req_valid_i),
  .req_log_i(req_log_i), .req_ready_o(req_ready_o), .req_abort_o(req_abort_o), .err_valid_i(err_valid_i),
  .err_host_fault_i(err_host_fault_i), .err_ready_o(err_ready_o), .byte_o(byte_o));

/* tb/lgd_host.sv */
// Host model: raises log read requests and holds them until taken.
// Assumes the caller enters just after a rising clock edge.
`timescale 1ns/1ns
module lgd_host
  import lgd_pkg::*;
(
  // Clock
  input wire logic ref_clk_i,
  // Request side
  input wire logic req_ready_i,
  output logic req_valid_o,
  output logic [7:0] req_log_o
);
  initial
  begin
    req_valid_o = 1'b0;
    req_log_o = 8'h00;
  end
  // A gap lets the host ask promptly or slowly
  task automatic read_log(input logic [7:0] addr, input int gap);
    int k;
    begin
      k = 0;
      repeat (gap) @(posedge ref_clk_i);
      if (gap > 0)
        #1;
      req_valid_o = 1'b1;
      req_log_o = addr;
      do
      begin
        @(posedge ref_clk_i);
        k++;
      end
      while (!req_ready_i && k < 1000);
      #1;
      req_valid_o = 1'b0;
      // Released address shows the inverse, never a stale copy
      req_log_o = ~addr;
    end
  endtask
endmodule

/* tb/tb_top.sv */
// Bench for the log unit: host reads, error events, expected-byte queue.
// Assumes the host model and the checker are compiled ahead of this file.
`timescale 1ns/1ns
module tb_top
  import lgd_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  lgd_support_type sup = 4'h0;
  logic err_valid = 1'b0;
  logic err_fault = 1'b0;
  logic req_valid, req_ready, req_abort, err_ready;
  logic [7:0] req_log;
  lgd_cmd_snap_type [4:0] cmd_snap = '0;
  lgd_err_snap_type err_snap = '0;
  lgd_byte_type byte_s;
  logic [31:0] seed = 32'h0000_1975;
  logic [8:0] exp_q[$];
  logic ab_q[$];
  logic [7:0] rec[4][124];
  int n_err = 0;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  lgd_log_unit uut (.ref_clk_i(clk), .rst_b_i(rst_b), .support_i(sup), .req_valid_i(req_valid),
    .req_log_i(req_log), .req_ready_o(req_ready), .req_abort_o(req_abort), .err_valid_i(err_valid),
    .err_host_fault_i(err_fault), .cmd_snap_i(cmd_snap), .err_snap_i(err_snap), .err_ready_o(err_ready),
    .byte_o(byte_s));
  lgd_host host (.ref_clk_i(clk), .req_ready_i(req_ready), .req_valid_o(req_valid), .req_log_o(req_log));
  // ************************************************************
  // Expected sectors
  // ************************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic push_dir(input lgd_support_type s);
    logic [7:0] n;
    for (int i = 0; i < 512; i++)
    begin
      case (8'(i >> 1))
        8'h00, 8'h03: n = 8'h01;
        8'h10: n = {7'h00, s.ncq};
        8'h11: n = {7'h00, s.phy_events};
        8'h12: n = {7'h00, s.queue_mgmt};
        8'h15: n = {7'h00, s.rebuild};
        default: n = (i >= 'h100 && i < 'h140) ? 8'h10 : 8'h00;
      endcase
      exp_q.push_back({i == 511, i[0] ? 8'h00 : n});
    end
  endtask
  task automatic push_err();
    logic [7:0] img[512];
    logic [7:0] sum;
    sum = 8'h00;
    foreach (img[i]) img[i] = 8'h00;
    img[0] = 8'h01;
    img[2] = n_err == 0 ? 8'h00 : 8'((n_err - 1) % 4 + 1);
    foreach (rec[k, j]) img[4 + 124 * k + j] = rec[k][j];
    img[500] = 8'(n_err);
    img[501] = 8'(n_err >> 8);
    for (int i = 0; i < 511; i++)
      sum += img[i];
    img[511] = 8'h00 - sum;
    for (int i = 0; i < 512; i++)
      exp_q.push_back({i == 511, img[i]});
  endtask
  // ************************************************************
  // Stimulus
  // ************************************************************
  task automatic err_event(input logic fault);
    int s;
    int k;
    s = n_err % 4;
    k = 0;
    for (int i = 0; i < 5; i++)
      cmd_snap[i] = 136'({rnd(), rnd(), rnd(), rnd(), rnd()});
    err_snap = 264'({rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd(), rnd()});
    err_snap.state = lgd_pwr_type'(4'(rnd() % 5));
    err_valid = 1'b1;
    err_fault = fault;
    // Event stands until ready is seen high at a rising edge
    do
    begin
      @(posedge clk);
      k++;
    end
    while (!err_ready && k < 200);
    #1;
    err_valid = 1'b0;
    k = 0;
    if (!fault)
    begin
      for (int i = 0; i < 5; i++)
        for (int b = 0; b < 18; b++)
          rec[s][18 * i + b] = b < 13 ? cmd_snap[i][135 - 8 * b -: 8] : b == 13 ? 8'h00
            : cmd_snap[i].stamp_ms[8 * (b - 14) +: 8];
      for (int b = 0; b < 34; b++)
        rec[s][90 + b] = b == 0 ? 8'h00 : b < 12 ? err_snap[263 - 8 * (b - 1) -: 8]
          : b < 31 ? err_snap.vendor[b - 12] : b == 31 ? {err_snap.state_vendor, err_snap.state}
          : err_snap.life_hours[8 * (b - 32) +: 8];
      n_err++;
    end
    // Snapshots must stand until the record is written
    do
    begin
      @(posedge clk);
      k++;
    end
    while (!err_ready && k < 200);
    #1;
  endtask
  task automatic drain();
    for (int k = 0; k < 700 && exp_q.size() + ab_q.size() != 0; k++)
      @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
  endtask
  // ************************************************************
  // Comparison and verdict
  // ************************************************************
  task automatic chk_byte(input logic [8:0] got);
    logic [8:0] e;
    logic ok;
    n_checks++;
    ok = exp_q.size() != 0;
    e = ok ? exp_q.pop_front() : 9'h000;
    if (!ok || got !== e)
    begin
      errors++;
      $display("unexpected byte at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task automatic chk_abort();
    n_checks++;
    if (ab_q.size() == 0 || ab_q.pop_front() !== 1'b1)
    begin
      errors++;
      $display("unexpected abort at %0t", $time);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (rst_b && byte_s.valid === 1'b1)
      chk_byte({byte_s.last, byte_s.data});
    if (rst_b && req_abort === 1'b1)
      chk_abort();
    if (cyc == 20000)
    begin
      errors++;
      $display("unexpected timeout at %0t", $time);
      wrap_up();
    end
  end
  initial
  begin
    foreach (rec[i, j]) rec[i][j] = 8'h00;
    repeat (16) @(posedge clk);
    #1;
    rst_b = 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      sup = i == 0 ? 4'hF : i == 1 ? 4'(rnd()) : 4'h0;
      push_dir(sup);
      host.read_log(8'h00, i);
      drain();
    end
    push_err();
    host.read_log(8'h03, 0);
    drain();
    for (int i = 0; i < 3; i++)
    begin
      ab_q.push_back(1'b1);
      host.read_log(i == 0 ? 8'h06 : i == 1 ? 8'h80 : 8'hFF, 1);
      drain();
    end
    err_event(1'b1);
    repeat (2) err_event(1'b0);
    push_err();
    host.read_log(8'h03, 0);
    drain();
    repeat (2) err_event(1'b0);
    // Read raised while the fifth record is still being written
    fork
      err_event(1'b0);
      begin
        repeat (3) @(posedge clk);
        #1;
        push_err();
        host.read_log(8'h03, 0);
      end
    join
    drain();
    n_checks++;
    if (exp_q.size() + ab_q.size() != 0)
    begin
      errors++;
      $display("unexpected leftover results at %0t", $time);
    end
    wrap_up();
  end
endmodule
